// [design/txrfm_pkg.sv]
// Package with register map, field layout, reset values and types of the transmitter control block
package txrfm_pkg;

  // Register offsets on the internal configuration port (7-bit address)
  localparam logic [6:0] TXRFM_ADDR_MAIN = 7'h00;
  localparam logic [6:0] TXRFM_ADDR_FREQ_2A = 7'h01;
  localparam logic [6:0] TXRFM_ADDR_FREQ_1A = 7'h02;
  localparam logic [6:0] TXRFM_ADDR_FREQ_0A = 7'h03;
  localparam logic [6:0] TXRFM_ADDR_FREQ_2B = 7'h04;
  localparam logic [6:0] TXRFM_ADDR_FREQ_1B = 7'h05;
  localparam logic [6:0] TXRFM_ADDR_FREQ_0B = 7'h06;
  localparam logic [6:0] TXRFM_ADDR_CLOCK = 7'h07;
  localparam logic [6:0] TXRFM_ADDR_DEV = 7'h08;
  localparam logic [6:0] TXRFM_ADDR_MODEM = 7'h09;
  localparam logic [6:0] TXRFM_ADDR_LEVEL = 7'h0A;
  localparam logic [6:0] TXRFM_ADDR_STATUS = 7'h0B;

  // Field positions
  localparam int TXRFM_MAIN_CHSEL = 0;
  localparam int TXRFM_MAIN_TXEN = 1;
  localparam int TXRFM_CLK_REFDIV_LSB = 0;
  localparam int TXRFM_CLK_PSB_LSB = 3;
  localparam int TXRFM_CLK_PSA_LSB = 5;
  localparam int TXRFM_DEV_MANT_LSB = 0;
  localparam int TXRFM_DEV_EXP_LSB = 4;
  localparam int TXRFM_DEV_SHAPE = 7;
  localparam int TXRFM_MODEM_BAND = 0;
  localparam int TXRFM_MODEM_FMT_LSB = 1;

  // Reset values
  localparam logic [7:0] TXRFM_RST_MAIN = 8'h00;
  localparam logic [23:0] TXRFM_RST_FREQ = 24'h000000;
  localparam logic [7:0] TXRFM_RST_CLOCK = 8'h01;
  localparam logic [7:0] TXRFM_RST_DEV = 8'h00;
  localparam logic [7:0] TXRFM_RST_MODEM = 8'h00;
  localparam logic [7:0] TXRFM_RST_LEVEL = 8'h00;

  // Data formats
  localparam logic [1:0] TXRFM_FMT_NRZ = 2'h0;
  localparam logic [1:0] TXRFM_FMT_MAN = 2'h1;

  // Rate arithmetic: symbol period in clock cycles is 8*(div+1)*DIV1*DIV2
  localparam int TXRFM_RATE_BASE = 8;
  // Carrier offsets in units of f_ref/65536: 3/4 and 3/2
  localparam logic [25:0] TXRFM_LOW_BAND_BASE = 26'h000C000;
  localparam logic [25:0] TXRFM_HIGH_BAND_BASE = 26'h0018000;

  // Timing: fastest transparent rate and the matching shortest bit time
  localparam real TXRFM_ASYNC_MAX_KBAUD = 153.6;
  localparam real TXRFM_CLK_MHZ = 25.0;
  localparam int TXRFM_ASYNC_MIN_CYC = int'($ceil(TXRFM_CLK_MHZ * 1000.0 / TXRFM_ASYNC_MAX_KBAUD));

  // Settings applied at symbol boundaries
  typedef struct packed {
    logic [2:0] ref_div;
    logic [2:0] symbol_prescale_a;
    logic [1:0] symbol_prescale_b;
    logic chan_sel;
    logic shaping;
    logic [2:0] shift_exponent;
    logic [3:0] shift_mantissa;
    logic band_choice_bit;
    logic [1:0] data_format;
  } txrfm_cfg_t;

  // Synthesizer drive bundle
  typedef struct packed {
    logic [25:0] freq_word;
    logic band_choice_bit;
    logic spur_spread_enable;
    logic amp_on;
    logic gauss_on;
    logic symbol;
  } txrfm_synth_t;

endpackage

// [design/txrfm_fifo.sv]
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
module txrfm_fifo import txrfm_pkg::*; #(
  parameter int WIDTH = 1,
  parameter int DEPTH = 16
) (
  input wire logic clock, // System clock
  input wire logic rst, // Synchronous reset
  input wire logic in_valid, // Write request
  output logic in_ready, // Not full
  input wire logic [WIDTH-1:0] in_data, // Write data
  output logic out_valid, // Not empty
  input wire logic out_ready, // Read accept
  output logic [WIDTH-1:0] out_data, // Head word
  output logic [$clog2(DEPTH):0] level // Words held
);
  localparam int AW = $clog2(DEPTH);

  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) $error("txrfm_fifo: DEPTH must be a power of two");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr_reg;
  logic [AW:0] rd_ptr_reg;
  wire logic push = in_valid && in_ready;
  wire logic pop = out_valid && out_ready;

  // Extra pointer bit tells full from empty
  assign in_ready = (wr_ptr_reg - rd_ptr_reg) != (AW + 1)'(DEPTH);
  assign out_valid = wr_ptr_reg != rd_ptr_reg;
  assign out_data = mem[rd_ptr_reg[AW-1:0]];
  assign level = wr_ptr_reg - rd_ptr_reg;

  // Storage array, no reset needed
  always_ff @(posedge clock) begin
    if (push) mem[wr_ptr_reg[AW-1:0]] <= in_data;
  end

  // Pointers
  always_ff @(posedge clock) begin
    if (rst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      if (push) wr_ptr_reg <= wr_ptr_reg + 1'b1;
      if (pop) rd_ptr_reg <= rd_ptr_reg + 1'b1;
    end
  end
endmodule

// [design/txrfm_ctrl.sv]
// Transmitter rate, channel, deviation, modulation and power control
//
// Summary of operation
// - Symbol period is 8*(div+1)*DIV1*DIV2 crystal cycles
// - First prescaler codes give 2.5 to 64
// - Second prescaler codes give 1,2,4,8
// - Transparent mode passes input bits at host rate
// - Two channel words, main bit selects one
// - Three bytes per word, low bit dithers
// - Lower band carrier: 3/4 plus word/32768
// - Upper band carrier: 3/2 plus word/16384
// - Band bit: 0 lower band, 1 upper
// - Reference is crystal over divider plus one
// - Deviation: four-bit mantissa, three-bit exponent
// - Zero minus deviation, one plus deviation
// - Zero mantissa selects full-depth on-off keying
// - Shaping bit enables Gaussian filtering when mantissa is nonzero, BT 0.5
// - Eight-bit output power code register
// - Manchester: zero rises, one falls, half rate
`timescale 1ns/1ps
module txrfm_ctrl import txrfm_pkg::*; #(
  parameter int FIFO_DEPTH = 16
) (
  input wire logic clock, // 25 MHz system clock
  input wire logic rst, // Synchronous reset, active high
  input wire logic cfg_wr, // Configuration write strobe
  input wire logic cfg_rd, // Configuration read strobe
  input wire logic [6:0] cfg_addr, // Register address
  input wire logic [7:0] cfg_wdata, // Write data
  output logic [7:0] cfg_rdata, // Read data, one cycle after cfg_rd
  input wire logic tx_bit_input, // Transmit data from host
  output logic tx_bit_clock, // Bit clock to host
  output txrfm_synth_t synth, // Synthesizer and modulator drive
  output logic [7:0] output_level_code // Power amplifier code
);

  initial begin
    if (FIFO_DEPTH < 2) $error("txrfm_ctrl: FIFO_DEPTH too small");
  end

  localparam int LW = $clog2(FIFO_DEPTH) + 1;

  // Software registers
  logic [7:0] main_reg;
  logic [23:0] freq_a_reg;
  logic [23:0] freq_b_reg;
  logic [7:0] clock_reg;
  logic [7:0] dev_reg;
  logic [7:0] modem_reg;
  logic [7:0] output_level_code_reg;
  logic [7:0] cfg_rdata_reg;

  // Applied settings
  txrfm_cfg_t act_reg;
  logic [23:0] act_word_reg;

  // Timing and data path state
  logic [15:0] div_cnt_reg;
  logic bclk_reg;
  logic phase_reg;
  logic man_bit_reg;
  logic sym_reg;
  logic sym_next;
  txrfm_synth_t synth_reg;
  txrfm_synth_t synth_next;

  // Address decode
  wire logic wr_main = cfg_wr && cfg_addr == TXRFM_ADDR_MAIN;
  wire logic wr_f2a = cfg_wr && cfg_addr == TXRFM_ADDR_FREQ_2A;
  wire logic wr_f1a = cfg_wr && cfg_addr == TXRFM_ADDR_FREQ_1A;
  wire logic wr_f0a = cfg_wr && cfg_addr == TXRFM_ADDR_FREQ_0A;
  wire logic wr_f2b = cfg_wr && cfg_addr == TXRFM_ADDR_FREQ_2B;
  wire logic wr_f1b = cfg_wr && cfg_addr == TXRFM_ADDR_FREQ_1B;
  wire logic wr_f0b = cfg_wr && cfg_addr == TXRFM_ADDR_FREQ_0B;
  wire logic wr_clock = cfg_wr && cfg_addr == TXRFM_ADDR_CLOCK;
  wire logic wr_dev = cfg_wr && cfg_addr == TXRFM_ADDR_DEV;
  wire logic wr_modem = cfg_wr && cfg_addr == TXRFM_ADDR_MODEM;
  wire logic wr_level = cfg_wr && cfg_addr == TXRFM_ADDR_LEVEL;

  // Staged settings as software wrote them
  txrfm_cfg_t stage;
  assign stage.ref_div = clock_reg[TXRFM_CLK_REFDIV_LSB +: 3];
  assign stage.symbol_prescale_b = clock_reg[TXRFM_CLK_PSB_LSB +: 2];
  assign stage.symbol_prescale_a = clock_reg[TXRFM_CLK_PSA_LSB +: 3];
  assign stage.chan_sel = main_reg[TXRFM_MAIN_CHSEL];
  assign stage.shift_mantissa = dev_reg[TXRFM_DEV_MANT_LSB +: 4];
  assign stage.shift_exponent = dev_reg[TXRFM_DEV_EXP_LSB +: 3];
  assign stage.shaping = dev_reg[TXRFM_DEV_SHAPE];
  assign stage.band_choice_bit = modem_reg[TXRFM_MODEM_BAND];
  assign stage.data_format = modem_reg[TXRFM_MODEM_FMT_LSB +: 2];

  wire logic tx_en = main_reg[TXRFM_MAIN_TXEN];
  wire logic is_async = act_reg.data_format[1];
  wire logic is_man = act_reg.data_format == TXRFM_FMT_MAN;

  // First prescaler in half units so that 2.5, 7.5 and 12.5 stay integer
  function automatic logic [7:0] div1_x2(input logic [2:0] code);
    logic [7:0] f;
    f = 8'h05;
    unique case (code)
      3'h0: f = 8'h05; // 2.5
      3'h1: f = 8'h06; // 3
      3'h2: f = 8'h08; // 4
      3'h3: f = 8'h0F; // 7.5
      3'h4: f = 8'h19; // 12.5
      3'h5: f = 8'h50; // 40
      3'h6: f = 8'h60; // 48
      3'h7: f = 8'h80; // 64
    endcase
    return f;
  endfunction

  // Symbol period: 8 * (div+1) * DIV1 * DIV2 = 4 * (div+1) * 2*DIV1 << code_b
  wire logic [3:0] ref_plus1 = {1'b0, act_reg.ref_div} + 4'h1;
  wire logic [11:0] ref_x_div1 = {8'h00, ref_plus1} * {4'h0, div1_x2(act_reg.symbol_prescale_a)};
  wire logic [15:0] period = {2'b00, ref_x_div1, 2'b00} << act_reg.symbol_prescale_b;
  wire logic [15:0] half_period = {1'b0, period[15:1]};
  wire logic sym_tick = tx_en && !is_async && div_cnt_reg >= period - 16'h0001;
  wire logic half_tick = tx_en && !is_async && div_cnt_reg == half_period - 16'h0001;

  // Settings land only between symbols; idle or transparent mode applies at once
  wire logic apply_cfg = !tx_en || is_async || sym_tick;

  // Bit clock edges: NRZ rises every symbol, Manchester every other symbol
  wire logic bclk_rise = sym_tick && (!is_man || !phase_reg);
  wire logic bclk_fall = is_man ? (sym_tick && phase_reg) : half_tick;

  // FIFO between sampled host bits and the modulator
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_out_data;
  logic [LW-1:0] fifo_level;
  wire logic push = bclk_rise && fifo_in_ready;
  wire logic pop = sym_tick && (!is_man || !phase_reg);

  txrfm_fifo #(.WIDTH(1), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clock(clock),
    .rst(rst || !tx_en),
    .in_valid(push),
    .in_ready(fifo_in_ready),
    .in_data(tx_bit_input),
    .out_valid(fifo_out_valid),
    .out_ready(pop),
    .out_data(fifo_out_data),
    .level(fifo_level)
  );

  // Carrier word in units of f_ref/65536; word[23:1] is frequency, word[0] spur_spread_enable
  wire logic [22:0] freq_field = act_word_reg[23:1];
  wire logic dith = act_word_reg[0];
  wire logic [25:0] low_carrier = TXRFM_LOW_BAND_BASE + {2'b00, freq_field, 1'b0} + {25'h0, dith};
  wire logic [25:0] high_carrier = TXRFM_HIGH_BAND_BASE + {1'b0, freq_field, 2'b00} + {24'h0, dith, 1'b0};
  wire logic [25:0] carrier = act_reg.band_choice_bit ? high_carrier : low_carrier;

  // Deviation: mantissa * 2^(exp-16) lower band, 2^(exp-15) upper band
  wire logic [3:0] dev_shift = {1'b0, act_reg.shift_exponent} + {3'h0, act_reg.band_choice_bit};
  wire logic [25:0] deviation = 26'({22'h0, act_reg.shift_mantissa} << dev_shift);
  wire logic ook = act_reg.shift_mantissa == 4'h0;

  // Symbol selection per data format
  always_comb begin
    sym_next = sym_reg;
    if (!tx_en) begin
      sym_next = 1'b0;
    end else if (is_async) begin
      sym_next = tx_bit_input;
    end else if (sym_tick) begin
      if (is_man && phase_reg) begin
        sym_next = ~man_bit_reg;
      end else if (fifo_out_valid) begin
        sym_next = fifo_out_data;
      end else begin
        sym_next = 1'b0;
      end
    end
  end

  // Synthesizer drive: carrier minus deviation for zero, plus for one
  always_comb begin
    synth_next.band_choice_bit = act_reg.band_choice_bit;
    synth_next.spur_spread_enable = dith;
    synth_next.gauss_on = act_reg.shaping && !ook;
    synth_next.symbol = sym_reg;
    if (ook) begin
      synth_next.freq_word = carrier;
      synth_next.amp_on = tx_en && sym_reg;
    end else begin
      synth_next.freq_word = sym_reg ? carrier + deviation : carrier - deviation;
      synth_next.amp_on = tx_en;
    end
  end

  // Read mux; status shows FIFO fill, bit clock, phase and symbol
  wire logic [7:0] status = {1'b0, 4'(fifo_level), phase_reg, bclk_reg, sym_reg};
  logic [7:0] rd_mux;
  always_comb begin
    unique case (cfg_addr)
      TXRFM_ADDR_MAIN: rd_mux = main_reg;
      TXRFM_ADDR_FREQ_2A: rd_mux = freq_a_reg[23:16];
      TXRFM_ADDR_FREQ_1A: rd_mux = freq_a_reg[15:8];
      TXRFM_ADDR_FREQ_0A: rd_mux = freq_a_reg[7:0];
      TXRFM_ADDR_FREQ_2B: rd_mux = freq_b_reg[23:16];
      TXRFM_ADDR_FREQ_1B: rd_mux = freq_b_reg[15:8];
      TXRFM_ADDR_FREQ_0B: rd_mux = freq_b_reg[7:0];
      TXRFM_ADDR_CLOCK: rd_mux = clock_reg;
      TXRFM_ADDR_DEV: rd_mux = dev_reg;
      TXRFM_ADDR_MODEM: rd_mux = modem_reg;
      TXRFM_ADDR_LEVEL: rd_mux = output_level_code_reg;
      TXRFM_ADDR_STATUS: rd_mux = status;
      default: rd_mux = 8'h00;
    endcase
  end

  // Control and power registers
  always_ff @(posedge clock) begin
    if (rst) begin
      main_reg <= TXRFM_RST_MAIN;
      clock_reg <= TXRFM_RST_CLOCK;
      dev_reg <= TXRFM_RST_DEV;
      modem_reg <= TXRFM_RST_MODEM;
      output_level_code_reg <= TXRFM_RST_LEVEL;
    end else begin
      if (wr_main) main_reg <= cfg_wdata;
      if (wr_clock) clock_reg <= cfg_wdata;
      if (wr_dev) dev_reg <= cfg_wdata;
      if (wr_modem) modem_reg <= cfg_wdata;
      if (wr_level) output_level_code_reg <= cfg_wdata;
    end
  end

  // Channel words, one byte per address
  always_ff @(posedge clock) begin
    if (rst) begin
      freq_a_reg <= TXRFM_RST_FREQ;
      freq_b_reg <= TXRFM_RST_FREQ;
    end else begin
      if (wr_f2a) freq_a_reg[23:16] <= cfg_wdata;
      if (wr_f1a) freq_a_reg[15:8] <= cfg_wdata;
      if (wr_f0a) freq_a_reg[7:0] <= cfg_wdata;
      if (wr_f2b) freq_b_reg[23:16] <= cfg_wdata;
      if (wr_f1b) freq_b_reg[15:8] <= cfg_wdata;
      if (wr_f0b) freq_b_reg[7:0] <= cfg_wdata;
    end
  end

  // Applied settings and selected channel word
  always_ff @(posedge clock) begin
    if (rst) begin
      act_reg <= '0;
      act_word_reg <= TXRFM_RST_FREQ;
    end else if (apply_cfg) begin
      act_reg <= stage;
      act_word_reg <= stage.chan_sel ? freq_b_reg : freq_a_reg;
    end
  end

  // Symbol rate divider; wrap on >= so a shrunken period cannot run away
  always_ff @(posedge clock) begin
    if (rst || !tx_en || is_async) begin
      div_cnt_reg <= 16'h0000;
    end else if (sym_tick) begin
      div_cnt_reg <= 16'h0000;
    end else begin
      div_cnt_reg <= div_cnt_reg + 16'h0001;
    end
  end

  // Bit clock and Manchester phase; transparent mode parks the clock
  always_ff @(posedge clock) begin
    if (rst || !tx_en) begin
      bclk_reg <= 1'b0;
      phase_reg <= 1'b0;
    end else if (is_async) begin
      bclk_reg <= act_reg.data_format[0];
      phase_reg <= 1'b0;
    end else begin
      if (bclk_rise) bclk_reg <= 1'b1;
      else if (bclk_fall) bclk_reg <= 1'b0;
      if (sym_tick) phase_reg <= is_man ? ~phase_reg : 1'b0;
    end
  end

  // Held Manchester bit; first half carries the bit, second its inverse
  always_ff @(posedge clock) begin
    if (rst) begin
      man_bit_reg <= 1'b0;
    end else if (sym_tick && is_man && !phase_reg) begin
      man_bit_reg <= fifo_out_valid ? fifo_out_data : 1'b0;
    end
  end

  // Output stage, all outputs registered
  always_ff @(posedge clock) begin
    if (rst) begin
      sym_reg <= 1'b0;
      synth_reg <= '0;
      cfg_rdata_reg <= 8'h00;
    end else begin
      sym_reg <= sym_next;
      synth_reg <= synth_next;
      if (cfg_rd) cfg_rdata_reg <= rd_mux;
    end
  end

  assign synth = synth_reg;
  assign tx_bit_clock = bclk_reg;
  assign output_level_code = output_level_code_reg;
  assign cfg_rdata = cfg_rdata_reg;

endmodule

// [testbench/txrfm_ctrl_assertions.sv]
// Port checker for the transmitter control block
`timescale 1ns/1ps
module txrfm_chk import txrfm_pkg::*; #(
  parameter int FIFO_DEPTH = 16
) (
  input wire logic clock, // Clock
  input wire logic rst, // Reset
  input wire logic cfg_wr, // Write
  input wire logic cfg_rd, // Read
  input wire logic [6:0] cfg_addr, // Address
  input wire logic [7:0] cfg_wdata, // Wdata
  input wire logic [7:0] cfg_rdata, // Rdata
  input wire logic tx_bit_input, // Host bit
  input wire logic tx_bit_clock, // Bit clock
  input wire txrfm_synth_t synth, // Drive
  input wire logic [7:0] output_level_code // Power
);
  localparam int D1 [8] = '{5, 6, 8, 15, 25, 80, 96, 128};
  logic [7:0] r [11];
  logic [19:0] q;
  logic [19:0] gap;
  logic bclk_d;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // Shadow of written registers, so expectations follow the host
  always_ff @(posedge clock) begin
    if (rst) begin
      for (int i = 0; i < 11; i++) r[i] <= (i == 7) ? TXRFM_RST_CLOCK : 8'h00;
    end else if (cfg_wr && cfg_addr < TXRFM_ADDR_STATUS) begin
      r[cfg_addr[3:0]] <= cfg_wdata;
    end
  end
  // Quiet time since a write; spacing of bit clock rises
  always_ff @(posedge clock) begin
    bclk_d <= tx_bit_clock;
    q <= (rst || cfg_wr) ? 20'h0 : ((q == 20'hFFFFF) ? q : q + 20'h1);
    gap <= (tx_bit_clock && !bclk_d) ? 20'h1 : gap + 20'h1;
  end
  // Expected figures from the shadow; settled waits out symbol-boundary lag
  wire band = r[9][0];
  wire en = r[0][1];
  wire sync = !r[9][2];
  wire [3:0] mant = r[8][3:0];
  wire [23:0] fw = r[0][0] ? {r[4], r[5], r[6]} : {r[1], r[2], r[3]};
  wire [19:0] per = 20'(4 * (r[7][2:0] + 1) * D1[r[7][7:5]]) << r[7][4:3];
  wire [19:0] gexp = (r[9][2:1] == TXRFM_FMT_MAN) ? {per[18:0], 1'b0} : per;
  wire settled = q > (sync ? gexp * 3 + 20'd8 : 20'd4);
  wire [25:0] car = band ? TXRFM_HIGH_BAND_BASE + {1'b0, fw, 1'b0} : TXRFM_LOW_BAND_BASE + {2'b00, fw};
  wire [25:0] dev = {22'h0, mant} << ({1'b0, r[8][6:4]} + band);
  a_level_write: assert property (cfg_wr && cfg_addr == TXRFM_ADDR_LEVEL |=>
    output_level_code == $past(cfg_wdata)) else $error("level code not loaded");
  a_level_read: assert property (cfg_rd && !cfg_wr && cfg_addr == TXRFM_ADDR_LEVEL |=>
    cfg_rdata == $past(output_level_code)) else $error("level readback wrong");
  a_rdata_hold: assert property (!cfg_rd |=> $stable(cfg_rdata)) else $error("read data moved");
  a_unmapped_zero: assert property (cfg_rd && cfg_addr > TXRFM_ADDR_STATUS |=> cfg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_bclk_period: assert property (settled && en && sync && tx_bit_clock && !bclk_d |->
    gap == gexp) else $error("bit clock period wrong");
  a_bclk_high: assert property ($rose(tx_bit_clock) |=> tx_bit_clock [*8]) else $error("bit clock high too short");
  a_ook_keying: assert property (settled && en && sync && mant == 4'h0 |->
    synth.amp_on == synth.symbol && !synth.gauss_on && synth.freq_word == car) else $error("keying wrong");
  a_fsk_shift: assert property (settled && en && sync && mant != 4'h0 |->
    synth.freq_word == (synth.symbol ? car + dev : car - dev) && synth.gauss_on == r[8][7])
    else $error("shift wrong");
  a_spur_band: assert property (settled && en && sync |->
    synth.spur_spread_enable == fw[0] && synth.band_choice_bit == band) else $error("spur_spread_enable or band wrong");
  a_direct_bit: assert property (settled && en && !sync |->
    synth.symbol == $past(tx_bit_input, 2)) else $error("direct bit late");
  a_boundary_only: assert property (en && sync && $past(en) && $past(sync) &&
    synth.freq_word != $past(synth.freq_word) |-> $past(tx_bit_clock) != $past(tx_bit_clock, 2))
    else $error("setting applied mid symbol");
endmodule
bind txrfm_ctrl txrfm_chk #(.FIFO_DEPTH(FIFO_DEPTH)) chk (.clock(clock), .rst(rst), .cfg_wr(cfg_wr),
  .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
  .tx_bit_input(tx_bit_input), .tx_bit_clock(tx_bit_clock), .synth(synth), .output_level_code(output_level_code));

// [testbench/txrfm_host.sv]
// Host model presenting transmit bits, lsb first
`timescale 1ns/1ps
module txrfm_host (
  input wire logic clock, // Clock
  input wire logic load, // New pattern
  input wire logic [15:0] pattern, // Bits
  input wire logic tx_bit_clock, // From device
  output logic tx_bit_input // To device
);
  logic [15:0] sh = 16'h0000;
  logic seen = 1'b0;
  // Shift just after the edge that follows a falling bit clock; data then stands for the next rise
  always @(posedge clock) begin
    seen <= tx_bit_clock;
    if (load) sh <= pattern;
    else if (seen && !tx_bit_clock) sh <= {1'b0, sh[15:1]};
  end
  assign tx_bit_input = sh[0];
endmodule

// [testbench/testbench.sv]
// Self-checking bench for the transmitter control block
`timescale 1ns/1ps
`define CHK(n, e, v) begin n_tests++; if ((v) !== (e)) begin err_count++; $display("BAD %s exp %h got %h", n, e, v); end end
module testbench import txrfm_pkg::*; ;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic cfg_wr = 1'b0;
  logic cfg_rd = 1'b0;
  logic load = 1'b0;
  logic [6:0] cfg_addr = 7'h00;
  logic [7:0] cfg_wdata = 8'h00;
  logic [15:0] pattern = 16'h0000;
  logic tx_bit_input, tx_bit_clock;
  logic [7:0] cfg_rdata, output_level_code;
  txrfm_synth_t synth;
  logic s [16];
  int err_count = 0;
  int n_tests = 0;
  always #20 clock = ~clock;
  txrfm_ctrl #(.FIFO_DEPTH(16)) uut (.clock(clock), .rst(rst), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
    .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .tx_bit_input(tx_bit_input),
    .tx_bit_clock(tx_bit_clock), .synth(synth), .output_level_code(output_level_code));
  txrfm_host host (.clock(clock), .load(load), .pattern(pattern), .tx_bit_clock(tx_bit_clock),
    .tx_bit_input(tx_bit_input));
  // Register port cycles, changed at the falling edge
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(negedge clock);
    cfg_wr = 1'b1;
    cfg_addr = a;
    cfg_wdata = d;
    @(negedge clock);
    cfg_wr = 1'b0;
  endtask
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    @(negedge clock);
    cfg_rd = 1'b1;
    cfg_addr = a;
    @(negedge clock);
    cfg_rd = 1'b0;
    d = cfg_rdata;
  endtask
  task automatic load_pat(input logic [15:0] p);
    @(negedge clock);
    load = 1'b1;
    pattern = p;
    @(negedge clock);
    load = 1'b0;
  endtask
  // Bounded wait for a bit clock level
  task automatic wait_bclk(input logic v);
    int k;
    k = 0;
    while (tx_bit_clock !== v && k < 2000) begin
      @(negedge clock);
      k++;
    end
    `CHK("bclk wait", 1'b1, k < 2000)
  endtask
  // Symbol at each fall is the first half; before the next rise, the second
  task automatic collect(input int n, input logic manch);
    for (int i = 0; i < n; i++) begin
      wait_bclk(1'b1);
      wait_bclk(1'b0);
      s[i] = synth.symbol;
      if (manch) begin
        wait_bclk(1'b1);
        `CHK("second half", ~s[i], synth.symbol)
      end
    end
  endtask
  // Pattern starts with a one, so leading idle zeros mark the pipeline delay
  task automatic chk_stream(input logic [15:0] p, input int n);
    int j;
    j = 0;
    while (j < 4 && s[j] !== 1'b1) j++;
    `CHK("lead zeros", 1'b1, j < 4)
    for (int i = 0; i < n; i++) `CHK("symbol", p[i], s[j + i])
  endtask
  task automatic t_reset();
    logic [7:0] d;
    `CHK("level out", 8'h00, output_level_code)
    `CHK("synth", 32'h0, synth)
    for (int a = 0; a < 12; a++) begin
      rd(7'(a), d);
      `CHK("reset reg", (a == 7) ? TXRFM_RST_CLOCK : 8'h00, d)
    end
    rd(7'h7F, d);
    `CHK("unmapped", 8'h00, d)
  endtask
  task automatic t_regs();
    logic [7:0] d, v;
    for (int a = 0; a < 12; a++) wr(7'(a), 8'hA4 + 8'(a) * 8'h13);
    wr(7'h20, 8'hFF);
    for (int a = 0; a < 11; a++) begin
      rd(7'(a), d);
      `CHK("reg rw", 8'hA4 + 8'(a) * 8'h13, d)
    end
    rd(7'h20, d);
    `CHK("unmapped wr", 8'h00, d)
    v = 8'h00;
    while (v <= 8'hC0) begin
      wr(TXRFM_ADDR_LEVEL, v);
      `CHK("level out", v, output_level_code)
      v = (v == 8'h0F) ? 8'h50 : v + ((v < 8'h0F) ? 8'h03 : 8'h10);
    end
    wr(TXRFM_ADDR_MAIN, 8'h00);
  endtask
  task automatic t_nrz();
    wr(TXRFM_ADDR_CLOCK, 8'h02);
    wr(TXRFM_ADDR_DEV, 8'hA3);
    wr(TXRFM_ADDR_MODEM, 8'h00);
    wr(TXRFM_ADDR_FREQ_2A, 8'h12);
    wr(TXRFM_ADDR_FREQ_1A, 8'h34);
    wr(TXRFM_ADDR_FREQ_0A, 8'h57);
    load_pat(16'h6A5B);
    wr(TXRFM_ADDR_MAIN, 8'h02);
    collect(14, 1'b0);
    chk_stream(16'h6A5B, 10);
    wait_bclk(1'b1);
    wr(TXRFM_ADDR_DEV, 8'h35);
    collect(3, 1'b0);
    wr(TXRFM_ADDR_MAIN, 8'h00);
    repeat (3) @(negedge clock);
    `CHK("amp off", 1'b0, synth.amp_on)
    `CHK("bclk off", 1'b0, tx_bit_clock)
  endtask
  task automatic t_manch();
    wr(TXRFM_ADDR_CLOCK, 8'h2A);
    wr(TXRFM_ADDR_DEV, 8'h40);
    wr(TXRFM_ADDR_MODEM, 8'h03);
    wr(TXRFM_ADDR_FREQ_2B, 8'h56);
    wr(TXRFM_ADDR_FREQ_1B, 8'h78);
    wr(TXRFM_ADDR_FREQ_0B, 8'h9B);
    load_pat(16'h00B5);
    wr(TXRFM_ADDR_MAIN, 8'h03);
    collect(10, 1'b1);
    chk_stream(16'h00B5, 7);
    // Let the first half of the last symbol pair finish before switching off
    wait_bclk(1'b0);
    wr(TXRFM_ADDR_MAIN, 8'h00);
  endtask
  task automatic t_transp();
    wr(TXRFM_ADDR_MODEM, 8'h06);
    wr(TXRFM_ADDR_MAIN, 8'h02);
    repeat (4) @(negedge clock);
    `CHK("parked clock", 1'b1, tx_bit_clock)
    for (int b = 0; b < 2; b++) begin
      load_pat({15'h0, b == 0});
      repeat (TXRFM_ASYNC_MIN_CYC) @(negedge clock);
      `CHK("direct bit", b == 0, synth.symbol)
    end
    wr(TXRFM_ADDR_MODEM, 8'h04);
    repeat (3) @(negedge clock);
    `CHK("parked clock", 1'b0, tx_bit_clock)
    wr(TXRFM_ADDR_MAIN, 8'h00);
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Watchdog, several times the expected run length
  initial begin
    repeat (30000) @(posedge clock);
    err_count++;
    give_verdict();
  end
  initial begin
    repeat (2) @(negedge clock);
    rst = 1'b0;
    t_reset();
    t_regs();
    t_nrz();
    t_manch();
    t_transp();
    give_verdict();
  end
endmodule
